// ==== design/backlight_enable_brightness_ctrl.v ====
// Enable, state and brightness code control for a three-string backlight
`timescale 1ns/1ps
`default_nettype none
`include "backlight_defs.vh"
module backlight_enable_brightness_ctrl #(
	parameter RAMP_CYCLES   = `RAMP_STEP_CYCLES,   // Cycles per ramp step
	parameter SAMPLE_CYCLES = `PWM_SAMPLE_CYCLES   // Cycles per PWM sample
) (
	input  wire        clk_sys,                // System clock, 200 MHz
	input  wire        rst,                    // Sync reset, active high
	input  wire        master_enable_pin,      // Master enable, low = shutdown
	input  wire        pwm_in,                 // PWM dimming input
	input  wire        reg_wr,                 // Register write strobe
	input  wire        reg_rd,                 // Register read strobe
	input  wire [7:0]  reg_addr,               // Register address
	input  wire [7:0]  reg_wdata,              // Register write data
	output reg  [7:0]  reg_rdata_q,            // Register read data
	output reg  [1:0]  op_state_q,             // Operating state
	output wire        low_power,              // Shutdown-level current mode
	output reg  [2:0]  sink_enable_q,          // Per-string sink enables
	output reg  [10:0] ramp_code_q,            // Ramped 11-bit code
	output wire [31:0] string_sink_current     // Per-string current, nA
);
	// ==========================================================
	// Register storage
	reg [7:0] enable_control_q;        // Chip and string enables
	reg [7:0] brightness_control_q;    // Mode and curve select
	reg [7:0] brightness_code_low_q;   // Code bits [2:0]
	reg [7:0] brightness_code_high_q;  // Code bits [10:3]
	wire      ramp_busy;               // Ramp still moving, shown in status

	// Field views
	wire       chip_enable = enable_control_q[`BIT_CHIP_ENABLE];
	wire [2:0] string_en   = enable_control_q[`FLD_STRING_EN_HI:`FLD_STRING_EN_LO];
	wire [1:0] brt_mode    = brightness_control_q[`FLD_BRT_MODE_HI:`FLD_BRT_MODE_LO];
	wire       exponential_curve_select = brightness_control_q[`BIT_EXP_CURVE_SELECT];

	// Register code: high register holds MSBs, low register three LSBs
	wire [10:0] reg_code = {brightness_code_high_q,
		brightness_code_low_q[`FLD_CODE_LOW_HI:0]};

	// Whole device held in reset while pin is low or reset is asserted
	wire dev_reset = rst || !master_enable_pin;

	// ==========================================================
	// Register writes; pin low returns all defaults and ignores the bus.
	// Standby never touches these, so programmed values survive it.
	always @(posedge clk_sys)
	begin
		if (dev_reset)
		begin
			enable_control_q       <= `RST_ENABLE_CONTROL;
			brightness_control_q   <= `RST_BRIGHTNESS_CONTROL;
			brightness_code_low_q  <= `RST_BRIGHTNESS_CODE_LOW;
			brightness_code_high_q <= `RST_BRIGHTNESS_CODE_HIGH;
		end
		else if (reg_wr)
		begin
			// Unused bits are dropped on write so they read back zero
			if (reg_addr == `OFS_ENABLE_CONTROL)
				enable_control_q <= {4'h0, reg_wdata[3:0]};
			else if (reg_addr == `OFS_BRIGHTNESS_CONTROL)
				brightness_control_q <= {reg_wdata[7:5], 5'h00};
			else if (reg_addr == `OFS_BRIGHTNESS_CODE_LOW)
				brightness_code_low_q <= {5'h00, reg_wdata[2:0]};
			else if (reg_addr == `OFS_BRIGHTNESS_CODE_HIGH)
				brightness_code_high_q <= reg_wdata;
		end
	end

	// ==========================================================
	// Register reads; one cycle after the strobe, unmapped reads zero
	always @(posedge clk_sys)
	begin
		if (dev_reset)
			reg_rdata_q <= 8'h00;
		else if (reg_rd)
		begin
			if (reg_addr == `OFS_ENABLE_CONTROL)
				reg_rdata_q <= enable_control_q;
			else if (reg_addr == `OFS_BRIGHTNESS_CONTROL)
				reg_rdata_q <= brightness_control_q;
			else if (reg_addr == `OFS_BRIGHTNESS_CODE_LOW)
				reg_rdata_q <= brightness_code_low_q;
			else if (reg_addr == `OFS_BRIGHTNESS_CODE_HIGH)
				reg_rdata_q <= brightness_code_high_q;
			else if (reg_addr == `OFS_OP_STATUS)
				// Live state and ramp activity
				reg_rdata_q <= {5'h00, ramp_busy, op_state_q};
			else
				reg_rdata_q <= 8'h00;
		end
	end

	// ==========================================================
	// PWM duty measurement, only running when a PWM mode is chosen
	wire        pwm_used = chip_enable && (brt_mode != `MODE_REG_ONLY);
	wire [10:0] pwm_code;              // Sampled duty code

	pwm_duty_meter #(
		.SAMPLE_DIV (SAMPLE_CYCLES),
		.CODE_W     (11)
	) u_pwm_meter (
		.clk_sys    (clk_sys),
		.rst        (dev_reset),
		.enable     (pwm_used),
		.pwm_in     (pwm_in),
		.pwm_code_q (pwm_code)
	);

	// ==========================================================
	// Source selection
	wire [21:0] product  = reg_code * pwm_code;           // Full product
	reg  [10:0] target_code;           // Code the ramp heads for

	always @*
	begin
		// Mode 00 register, 01 PWM, 1x product of both
		if (brt_mode == `MODE_REG_ONLY)
			target_code = reg_code;
		else if (brt_mode == `MODE_PWM_ONLY)
			target_code = pwm_code;
		else
			target_code = product[21:11];
	end

	// Standby when no string enabled or the selected source is zero;
	// in product modes either source zero also gives a zero product.
	wire standby_cond = (string_en == 3'h0) ||
		(target_code == 11'h000);

	// ==========================================================
	// Operating state
	reg [1:0] state_d;                 // Next operating state

	always @*
	begin
		// Chip enable bit overrides every other setting
		if (!chip_enable)
			state_d = `ST_DISABLED;
		else if (standby_cond)
			state_d = `ST_STANDBY;
		else
			state_d = `ST_ACTIVE;
	end

	always @(posedge clk_sys)
	begin
		if (dev_reset)
			op_state_q <= `ST_DISABLED;
		else
			op_state_q <= state_d;
	end

	// Disabled and standby both fall to shutdown-level current
	assign low_power = (op_state_q != `ST_ACTIVE);

	// ==========================================================
	// Sink enables: only while active, per string
	always @(posedge clk_sys)
	begin
		if (dev_reset)
			sink_enable_q <= 3'h0;
		else if (state_d == `ST_ACTIVE)
			sink_enable_q <= string_en;
		else
			sink_enable_q <= 3'h0;
	end

	// ==========================================================
	// Ramper: one code step per tick toward the target.
	// Slow stepping trades response time for flicker-free changes.
	reg  [15:0] ramp_div_q;            // Ramp tick divider
	wire        ramp_tick = (ramp_div_q == RAMP_CYCLES[15:0] - 16'h0001);
	wire [10:0] ramp_goal = (state_d == `ST_ACTIVE) ? target_code : 11'h000;
	assign ramp_busy = (ramp_code_q != ramp_goal);

	always @(posedge clk_sys)
	begin
		if (dev_reset || ramp_tick)
			ramp_div_q <= 16'h0000;
		else
			ramp_div_q <= ramp_div_q + 16'h0001;
	end

	always @(posedge clk_sys)
	begin
		if (dev_reset)
			ramp_code_q <= 11'h000;
		else if (state_d != `ST_ACTIVE)
			// Sinks are off; restart the ramp from zero next time
			ramp_code_q <= 11'h000;
		else if (ramp_tick && ramp_code_q < ramp_goal)
			ramp_code_q <= ramp_code_q + 11'h001;
		else if (ramp_tick && ramp_code_q > ramp_goal)
			ramp_code_q <= ramp_code_q - 11'h001;
	end

	// ==========================================================
	// Current mapping from the ramped code
	sink_current_map u_map (
		.clk_sys      (clk_sys),
		.rst          (dev_reset),
		.code         (ramp_code_q),
		.exp_sel      (exponential_curve_select),
		.current_na_q (string_sink_current)
	);
endmodule
`default_nettype wire

// ==== design/backlight_defs.vh ====
// Constants for the backlight enable and brightness control block
`ifndef BACKLIGHT_DEFS_VH
`define BACKLIGHT_DEFS_VH

// ==========================================================
// Register offsets (byte addresses on the serial register port)
`define OFS_ENABLE_CONTROL      8'h10
`define OFS_BRIGHTNESS_CONTROL  8'h11
`define OFS_BRIGHTNESS_CODE_LOW 8'h18
`define OFS_BRIGHTNESS_CODE_HIGH 8'h19
`define OFS_OP_STATUS           8'h1F

// ==========================================================
// Field positions
`define BIT_CHIP_ENABLE         0
`define FLD_STRING_EN_HI        3
`define FLD_STRING_EN_LO        1
`define FLD_BRT_MODE_HI         6
`define FLD_BRT_MODE_LO         5
`define BIT_EXP_CURVE_SELECT    7
`define FLD_CODE_LOW_HI         2

// ==========================================================
// Reset values: chip enabled, three strings, PWM source, linear
`define RST_ENABLE_CONTROL      8'h0F
`define RST_BRIGHTNESS_CONTROL  8'h20
`define RST_BRIGHTNESS_CODE_LOW 8'h00
`define RST_BRIGHTNESS_CODE_HIGH 8'h00

// ==========================================================
// Brightness source modes
`define MODE_REG_ONLY           2'h0
`define MODE_PWM_ONLY           2'h1

// ==========================================================
// Operating states
`define ST_DISABLED             2'h0
`define ST_STANDBY              2'h1
`define ST_ACTIVE               2'h2

// ==========================================================
// Timing
`define CLK_PERIOD_NS           5
`define RAMP_STEP_NS            977
`define RAMP_STEP_CYCLES        (`RAMP_STEP_NS / `CLK_PERIOD_NS)
`define PWM_SAMPLE_NS           250
`define PWM_SAMPLE_CYCLES       (`PWM_SAMPLE_NS / `CLK_PERIOD_NS)

// ==========================================================
// Current mapping in nanoamps
`define LIN_OFFSET_NA           32'd37806
`define LIN_STEP_NA             32'd12195
`define EXP_BASE_NA             32'd50000

`endif

// ==== design/pwm_duty_meter.v ====
// Sampled PWM duty meter giving an 11-bit brightness code
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_meter #(
	parameter SAMPLE_DIV = 50,  // Clock cycles per sample
	parameter CODE_W     = 11   // Code width
) (
	input  wire              clk_sys,    // System clock
	input  wire              rst,        // Sync reset, active high
	input  wire              enable,     // Meter running
	input  wire              pwm_in,     // PWM dimming input
	output reg  [CODE_W-1:0] pwm_code_q  // Measured duty code
);
	localparam [CODE_W-1:0] CODE_MAX = {CODE_W{1'b1}};
	reg [15:0]     div_q;     // Sample divider
	reg [CODE_W:0] win_q;     // Samples taken in window
	reg [CODE_W:0] high_q;    // High samples in window

	// ==========================================================
	// Window of 2^CODE_W samples; duty code is the high count
	always @(posedge clk_sys)
	begin
		if (rst || !enable)
		begin
			div_q      <= 16'h0000;
			win_q      <= {(CODE_W+1){1'b0}};
			high_q     <= {(CODE_W+1){1'b0}};
			pwm_code_q <= {CODE_W{1'b0}};
		end
		else if (div_q == SAMPLE_DIV[15:0] - 16'h0001)
		begin
			div_q <= 16'h0000;
			if (win_q[CODE_W])
			begin
				// Full window: a full-high window saturates at the top code
				pwm_code_q <= high_q[CODE_W] ? CODE_MAX : high_q[CODE_W-1:0];
				win_q      <= {(CODE_W+1){1'b0}};
				high_q     <= {(CODE_W+1){1'b0}};
			end
			else
			begin
				win_q  <= win_q + 1'b1;
				high_q <= high_q + {{CODE_W{1'b0}}, pwm_in};
			end
		end
		else
			div_q <= div_q + 16'h0001;
	end
endmodule
`default_nettype wire

// ==== design/sink_current_map.v ====
// Maps an 11-bit brightness code to sink current in nanoamps
`timescale 1ns/1ps
`default_nettype none
`include "backlight_defs.vh"
module sink_current_map (
	input  wire        clk_sys,        // System clock
	input  wire        rst,            // Sync reset, active high
	input  wire [10:0] code,           // Ramped brightness code
	input  wire        exp_sel,        // Exponential curve select
	output reg  [31:0] current_na_q    // Sink current, nanoamps
);
	// Base powers 1.003040572^(2^i) in Q16; approximate to about 1e-5
	wire [23:0] fac [0:10];
	assign fac[0]  = 24'h0100C7;
	assign fac[1]  = 24'h01018F;
	assign fac[2]  = 24'h010321;
	assign fac[3]  = 24'h01064B;
	assign fac[4]  = 24'h010CBE;
	assign fac[5]  = 24'h011A1F;
	assign fac[6]  = 24'h0136E7;
	assign fac[7]  = 24'h017993;
	assign fac[8]  = 24'h022CE1;
	assign fac[9]  = 24'h04BB6B;
	assign fac[10] = 24'h166505;

	// ==========================================================
	// Exponential chain: multiply in the factor of each set code bit
	wire [31:0] acc [0:11];
	assign acc[0] = `EXP_BASE_NA;
	genvar i;
	generate
		for (i = 0; i < 11; i = i + 1)
		begin : g_exp
			wire [55:0] prod = acc[i] * fac[i];
			assign acc[i+1] = code[i] ? prod[47:16] : acc[i];
		end
	endgenerate

	wire [31:0] lin_na = `LIN_OFFSET_NA + `LIN_STEP_NA * {21'h00000, code};

	// ==========================================================
	// Registered current; code zero always gives zero current
	always @(posedge clk_sys)
	begin
		if (rst || code == 11'h000)
			current_na_q <= 32'h00000000;
		else if (exp_sel)
			current_na_q <= acc[11];
		else
			current_na_q <= lin_na;
	end
endmodule
`default_nettype wire

// ==== tb/backlight_ctrl_sva.sv ====
// Port checker for the backlight enable and brightness block
`timescale 1ns/1ps
`default_nettype none
module backlight_ctrl_sva (
	input wire logic        clk_sys,             // Clock
	input wire logic        rst,                 // Sync reset
	input wire logic        master_enable_pin,   // Master enable
	input wire logic        reg_wr,              // Write strobe
	input wire logic        reg_rd,              // Read strobe
	input wire logic [7:0]  reg_addr,            // Address
	input wire logic [7:0]  reg_wdata,           // Write data
	input wire logic [7:0]  reg_rdata_q,         // Read data
	input wire logic [1:0]  op_state_q,          // State
	input wire logic        low_power,           // Low-power flag
	input wire logic [2:0]  sink_enable_q,       // Sink enables
	input wire logic [10:0] ramp_code_q,         // Ramped code
	input wire logic [31:0] string_sink_current  // Current, nA
);
	// ==========================================================
	// Helper: mirror of the curve select bit
	logic exp_q; // Exponential curve chosen
	// Follows accepted writes only, so shutdown writes leave it alone
	always @(posedge clk_sys)
	begin
		if (rst || !master_enable_pin)
			exp_q <= 1'b0;
		else if (reg_wr && reg_addr == 8'h11)
			exp_q <= reg_wdata[7];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Two samples away from active
	sequence s_idle2;
		(op_state_q != 2'h2)[*2];
	endsequence
	// ==========================================================
	// Assertions
	AST_PIN_LOW_OFF: assert property (!master_enable_pin |=> op_state_q == 2'h0 &&
		sink_enable_q == 3'h0 && ramp_code_q == 11'h000) else $error("not off after pin low");
	AST_LOW_POWER: assert property (low_power == (op_state_q != 2'h2))
		else $error("low power flag disagrees with state");
	AST_RDATA_HOLD: assert property (!reg_rd && master_enable_pin |=> $stable(reg_rdata_q))
		else $error("read data moved without a read");
	AST_RAMP_STEP: assert property (ramp_code_q != $past(ramp_code_q) |->
		ramp_code_q == $past(ramp_code_q) + 11'h001 ||
		ramp_code_q == $past(ramp_code_q) - 11'h001 || ramp_code_q == 11'h000)
		else $error("ramp jumped");
	AST_RAMP_IDLE_ZERO: assert property (s_idle2 |-> ramp_code_q == 11'h000)
		else $error("ramp not zero outside active");
	AST_SINKS_OFF: assert property (op_state_q == 2'h0 |-> sink_enable_q == 3'h0)
		else $error("sinks on while disabled");
	AST_ACTIVE_SINK: assert property (op_state_q == 2'h2 |-> sink_enable_q != 3'h0)
		else $error("active with no string");
	AST_CURRENT_ZERO: assert property (ramp_code_q == 11'h000 |=> string_sink_current == 32'h0)
		else $error("current for code zero");
	AST_CURRENT_LIN: assert property (master_enable_pin && ramp_code_q != 11'h000 && !exp_q |=>
		string_sink_current == 32'h000093AE + 32'h00002FA3 * {21'h0, $past(ramp_code_q)})
		else $error("linear current wrong");
endmodule
`default_nettype wire

// ==== tb/pwm_source.sv ====
// Pulse-width dimming source on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module pwm_source (
	input  wire logic clk_sys, // Clock
	input  wire logic pwm_sel, // Level asked by the bench
	output var  logic pwm_out  // Dimming level to the block
);
	// Level moves just after an edge, like a synchronous source
	initial pwm_out = 1'b0;
	always @(posedge clk_sys)
		pwm_out <= pwm_sel;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Testbench for the backlight enable and brightness block
`timescale 1ns/1ps
`default_nettype none
`include "backlight_defs.vh"
module tb;
	logic        clk_sys = 1'b0;           // 200 MHz clock
	logic        rst = 1'b1;               // Sync reset
	logic        master_enable_pin = 1'b1; // Master enable
	logic        pwm_sel = 1'b0;           // Level asked of source
	wire         pwm_in;                   // Source level
	logic        reg_wr = 1'b0;            // Write strobe
	logic        reg_rd = 1'b0;            // Read strobe
	logic [7:0]  reg_addr = 8'h00;         // Address
	logic [7:0]  reg_wdata = 8'h00;        // Write data
	wire  [7:0]  reg_rdata_q;              // Read data
	wire  [1:0]  op_state_q;               // State
	wire         low_power;                // Low-power flag
	wire  [2:0]  sink_enable_q;            // Sink enables
	wire  [10:0] ramp_code_q;              // Ramped code
	wire  [31:0] string_sink_current;      // Current, nA
	int          miscompares = 0;          // Mismatches
	int          checked = 0;              // Comparisons
	// Short counts keep the run small
	backlight_enable_brightness_ctrl #(.RAMP_CYCLES(2), .SAMPLE_CYCLES(1)) DUT (
		.clk_sys(clk_sys), .rst(rst), .master_enable_pin(master_enable_pin),
		.pwm_in(pwm_in), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .op_state_q(op_state_q),
		.low_power(low_power), .sink_enable_q(sink_enable_q), .ramp_code_q(ramp_code_q),
		.string_sink_current(string_sink_current));
	pwm_source src (.clk_sys(clk_sys), .pwm_sel(pwm_sel), .pwm_out(pwm_in));
	initial
		forever #2.5 clk_sys = ~clk_sys;
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Read back and compare; data is valid after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk({24'h0, reg_rdata_q}, {24'h0, e});
	endtask
	task automatic settle;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	// Bounded wait for the ramp to land on a code
	task automatic wait_ramp(input logic [10:0] v);
		for (int i = 0; i < 30000 && ramp_code_q !== v; i++)
			@(posedge clk_sys);
		#1;
		chk({21'h0, ramp_code_q}, {21'h0, v});
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_defaults;
		settle;
		chk(op_state_q, 2'h1);
		chk(low_power, 1'b1);
		rd(8'h10, `RST_ENABLE_CONTROL);
		rd(8'h11, `RST_BRIGHTNESS_CONTROL);
		rd(8'h18, `RST_BRIGHTNESS_CODE_LOW);
		rd(8'h19, `RST_BRIGHTNESS_CODE_HIGH);
		rd(8'h20, 8'h00);
	endtask
	task automatic t_pwm_start;
		pwm_sel <= 1'b1;
		wait_ramp(11'h7FF);
		chk(op_state_q, 2'h2);
		chk(sink_enable_q, 3'h7);
		#5;
		chk(string_sink_current, 32'h000093AE + 32'h00002FA3 * 32'h7FF);
	endtask
	task automatic t_reg_mode;
		real er;
		wr(8'h11, 8'h00);
		settle;
		chk(op_state_q, 2'h1);
		wr(8'h18, 8'hFF);
		rd(8'h18, 8'h07);
		wr(8'h19, 8'h01);
		wait_ramp(11'h00F);
		settle;
		chk(string_sink_current, 32'h000093AE + 32'h00002FA3 * 32'hF);
		wr(8'h11, 8'h80);
		settle;
		er = 50000.0 * (1.003040572 ** 15.0);
		chk(($itor(string_sink_current) > er - 100.0 &&
			$itor(string_sink_current) < er + 100.0) ? 1 : 0, 1);
	endtask
	task automatic t_product;
		wr(8'h11, 8'h40);
		settle;
		wait_ramp(11'h00E);
		wr(8'h11, 8'h60);
		settle;
		chk(ramp_code_q, 11'h00E);
		pwm_sel <= 1'b0;
		wait_ramp(11'h000);
		settle;
		chk(op_state_q, 2'h1);
	endtask
	// Register source first, then strings off and back on, then chip disable
	task automatic t_strings;
		wr(8'h11, 8'h00);
		settle;
		chk(op_state_q, 2'h2);
		wr(8'h10, 8'h01);
		settle;
		chk(op_state_q, 2'h1);
		wr(8'h10, 8'h0B);
		settle;
		chk(sink_enable_q, 3'h5);
		rd(8'h1F, 8'h06);
		wr(8'h10, 8'h0A);
		settle;
		chk(op_state_q, 2'h0);
		chk(sink_enable_q, 3'h0);
		rd(8'h19, 8'h01);
	endtask
	task automatic t_pin;
		@(posedge clk_sys);
		master_enable_pin <= 1'b0;
		wr(8'h19, 8'h55);
		settle;
		chk(op_state_q, 2'h0);
		chk(low_power, 1'b1);
		@(posedge clk_sys);
		master_enable_pin <= 1'b1;
		settle;
		rd(8'h10, `RST_ENABLE_CONTROL);
		rd(8'h19, 8'h00);
		wr(8'h19, 8'hAA);
		rd(8'h19, 8'hAA);
	endtask
	task automatic finish_test;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_defaults;
		t_pwm_start;
		t_reg_mode;
		t_product;
		t_strings;
		t_pin;
		finish_test;
	end
	// Cuts a hang short at well over twice the expected run
	initial
	begin
		#300000;
		miscompares++;
		finish_test;
	end
endmodule
bind backlight_enable_brightness_ctrl backlight_ctrl_sva u_sva (.clk_sys(clk_sys), .rst(rst),
	.master_enable_pin(master_enable_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
	.op_state_q(op_state_q), .low_power(low_power), .sink_enable_q(sink_enable_q),
	.ramp_code_q(ramp_code_q), .string_sink_current(string_sink_current));
`default_nettype wire
